// ### dcf_consts.svh
// Constants of the device control frame transmitter
// How it works
// - Register request builds and sends register frame
// - Register frame carries contents captured at request
// - Device bits request builds and sends frame
// - PIO request builds frame from application content
// - PIO frame holds status, byte count, interrupt
// - One PIO data frame follows, direction bit
// - No flow control while handing frame over
// - Mark last word, then await outcome
// - Illegal transition abandons register or PIO frame
// - Await link ending status before acting
// - Clean ending status returns to idle
// - Error status reported, same frame resent
// - Idle waits for request or arriving frame
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
`define DCF_WORD_W    32
`define DCF_MAX_WORDS 5
`define DCF_FRAME_W   160
`define DCF_LEN_W     3
`define DCF_LEN_RSF   3'h5
`define DCF_LEN_SDB   3'h2
`define DCF_LEN_PIO   3'h5
`define DCF_IDX_ZERO  3'h0
`define DCF_IDX_ONE   3'h1
`define DCF_TYPE_RSF  8'h01
`define DCF_TYPE_SDB  8'h02
`define DCF_TYPE_PIO  8'h03
`endif

// ### dcf_pkg.sv
// Types shared by the device control frame transmitter
`include "dcf_consts.svh"
package dcf_pkg;
   typedef enum logic [1:0] {KIND_NONE, KIND_RSF, KIND_SDB, KIND_PIO} dcf_kind_e;
   typedef struct packed {
      logic [7:0]  status;
      logic [7:0]  error;
      logic [7:0]  device;
      logic [47:0] lba;
      logic [15:0] count;
      logic        irq;
   } dcf_regs_s;
   typedef struct packed {
      dcf_regs_s   regs;
      logic [7:0]  estatus;
      logic [15:0] xfer;
      logic        dir;
   } dcf_pio_s;
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] error;
      logic       irq;
   } dcf_sdb_s;
   typedef struct packed {
      logic       rsvd_hi;
      logic       irq;
      logic       dir;
      logic [4:0] rsvd_lo;
   } dcf_flags_s;
   typedef struct packed {
      logic [15:0] w4_rsvd;
      logic [15:0] w4_xfer;
      logic [7:0]  w3_estatus;
      logic [7:0]  w3_rsvd;
      logic [15:0] w3_count;
      logic [7:0]  w2_rsvd;
      logic [23:0] w2_lba_hi;
      logic [7:0]  w1_device;
      logic [23:0] w1_lba_lo;
      logic [7:0]  w0_error;
      logic [7:0]  w0_status;
      dcf_flags_s  w0_flags;
      logic [7:0]  w0_type;
   } dcf_rfis_s;
   typedef struct packed {
      logic [31:0] w1_rsvd;
      logic [7:0]  w0_error;
      logic [7:0]  w0_status;
      dcf_flags_s  w0_flags;
      logic [7:0]  w0_type;
   } dcf_sfis_s;
   typedef struct packed {
      logic                   notify;
      logic                   valid;
      logic                   last;
      logic [`DCF_WORD_W-1:0] data;
   } dcf_tx_s;
   typedef struct packed {
      logic valid;
      logic err;
   } dcf_stat_s;
endpackage

// ### dcf_transmitter.sv
// Device transport sequencer for outbound control frames
`timescale 1ns/100ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_transmitter #(
   parameter logic [7:0] TYPE_RSF = `DCF_TYPE_RSF,
   parameter logic [7:0] TYPE_SDB = `DCF_TYPE_SDB,
   parameter logic [7:0] TYPE_PIO = `DCF_TYPE_PIO
) (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              req_rsf,
   input  wire dcf_pkg::dcf_regs_s rsf_in,
   input  wire logic              req_sdb,
   input  wire dcf_pkg::dcf_sdb_s  sdb_in,
   input  wire logic              req_pio,
   input  wire dcf_pkg::dcf_pio_s  pio_in,
   input  wire logic              link_rx_start,
   input  wire logic              link_illegal,
   input  wire dcf_pkg::dcf_stat_s link_stat,
   output var  dcf_pkg::dcf_tx_s   tx,
   output var  dcf_pkg::dcf_stat_s rep,
   output var  logic              busy,
   output var  logic              done,
   output var  logic              abandoned,
   output var  logic              pio_data_next,
   output var  logic              pio_data_dir
);
   import dcf_pkg::*;

   // Sequencer states; one build state per frame kind
   typedef enum logic [2:0] {
      ST_TRANSPORT_IDLE,
      ST_BUILD_REGISTER_STATUS_FRAME,
      ST_BUILD_DEVICE_BITS_FRAME,
      ST_BUILD_PIO_SETUP_FRAME,
      ST_AWAIT_TRANSMIT_OUTCOME
   } dcf_state_e;

   // Registered state, snapshots and the frame image
   dcf_state_e                                 state_r;
   dcf_state_e                                 state_nxt;
   dcf_kind_e                                  kind_r;
   dcf_kind_e                                  kind_nxt;
   logic                                       pend_rsf_r;
   logic                                       pend_sdb_r;
   logic                                       pend_pio_r;
   dcf_regs_s                                  snap_rsf_r;
   dcf_sdb_s                                   snap_sdb_r;
   dcf_pio_s                                   snap_pio_r;
   logic [`DCF_MAX_WORDS-1:0][`DCF_WORD_W-1:0] frame_r;
   logic [`DCF_LEN_W-1:0]                      len_r;
   logic [`DCF_LEN_W-1:0]                      idx_r;
   dcf_tx_s                                    tx_r;
   dcf_stat_s                                  rep_r;
   logic                                       done_r;
   logic                                       abandon_r;
   logic                                       pio_next_r;
   logic                                       pio_dir_r;

   // Frame image for one kind, taken from the held snapshots
   // Register and PIO frames share one layout; unused fields stay zero
   // The device bits frame is shorter and takes its own small layout
   // Snapshots are read here, so packing happens only at accept
   function automatic logic [`DCF_FRAME_W-1:0] dcf_pack(input dcf_kind_e k);
      dcf_rfis_s  rf;
      dcf_sfis_s  sf;
      dcf_flags_s fl;
      dcf_regs_s  rg;
      rf = '0;
      sf = '0;
      fl = '0;
      rg = (k == KIND_PIO) ? snap_pio_r.regs : snap_rsf_r;
      rf.w0_status  = rg.status;
      rf.w0_error   = rg.error;
      rf.w1_device  = rg.device;
      rf.w1_lba_lo  = rg.lba[23:0];
      rf.w2_lba_hi  = rg.lba[47:24];
      rf.w3_count   = rg.count;
      fl.irq        = rg.irq;
      if (k == KIND_PIO) begin
         fl.dir        = snap_pio_r.dir;
         rf.w3_estatus = snap_pio_r.estatus;
         rf.w4_xfer    = snap_pio_r.xfer;
         rf.w0_type    = TYPE_PIO;
      end else begin
         rf.w0_type    = TYPE_RSF;
      end
      rf.w0_flags = fl;
      if (k == KIND_SDB) begin
         fl          = '0;
         fl.irq      = snap_sdb_r.irq;
         sf.w0_flags  = fl;
         sf.w0_status = snap_sdb_r.status;
         sf.w0_error  = snap_sdb_r.error;
         sf.w0_type   = TYPE_SDB;
         return `DCF_FRAME_W'(sf);
      end
      return rf;
   endfunction

   // Word count for one kind
   function automatic logic [`DCF_LEN_W-1:0] dcf_len(input dcf_kind_e k);
      case (k)
         KIND_SDB: return `DCF_LEN_SDB;
         KIND_PIO: return `DCF_LEN_PIO;
         default:  return `DCF_LEN_RSF;
      endcase
   endfunction

   // Build state that belongs to a kind, used for first send and resend
   // One function for idle entry and retry keeps both on the same state
   function automatic dcf_state_e dcf_build_state(input dcf_kind_e k);
      case (k)
         KIND_SDB: return ST_BUILD_DEVICE_BITS_FRAME;
         KIND_PIO: return ST_BUILD_PIO_SETUP_FRAME;
         default:  return ST_BUILD_REGISTER_STATUS_FRAME;
      endcase
   endfunction

   // Stored image seen field by field; only the data direction reads it, resend sends frame_r words
   wire dcf_rfis_s frame_view   = frame_r;

   // Decode of the current state and the link events
   wire logic      in_idle      = (state_r == ST_TRANSPORT_IDLE);
   wire logic      in_wait      = (state_r == ST_AWAIT_TRANSMIT_OUTCOME);
   wire logic      in_build     = !in_idle && !in_wait;
   wire logic      last_beat    = in_build && (idx_r == len_r - `DCF_IDX_ONE);
   // Kill needs a build state, so late notices in the wait state drop out
   // Device bits frame has no abandon path, so the notification is ignored there
   wire logic      kill         = link_illegal && in_build && (kind_r != KIND_SDB);
   wire logic      stat_ok      = in_wait && link_stat.valid && !link_stat.err;
   wire logic      stat_bad     = in_wait && link_stat.valid && link_stat.err;

   // Idle arbitration: an arriving frame owns the link, requests stay pending
   wire logic      can_start    = in_idle && !link_rx_start;
   wire dcf_kind_e pick         = pend_rsf_r ? KIND_RSF :
                                  pend_sdb_r ? KIND_SDB :
                                  pend_pio_r ? KIND_PIO : KIND_NONE;
   wire logic      accept       = can_start && (pick != KIND_NONE);
   wire logic      take_rsf     = accept && (pick == KIND_RSF);
   wire logic      take_sdb     = accept && (pick == KIND_SDB);
   wire logic      take_pio     = accept && (pick == KIND_PIO);

   // Next state
   // Retry returns to the build state of the same kind, reusing its image
   // Status outside the wait and illegal notices in the wait are ignored
   always_comb begin
      state_nxt = state_r;
      kind_nxt  = kind_r;
      case (state_r)
         ST_TRANSPORT_IDLE: begin
            if (accept) begin
               state_nxt = dcf_build_state(pick);
               kind_nxt  = pick;
            end
         end
         ST_BUILD_REGISTER_STATUS_FRAME,
         ST_BUILD_PIO_SETUP_FRAME: begin
            if (kill) begin
               state_nxt = ST_TRANSPORT_IDLE;
               kind_nxt  = KIND_NONE;
            end else if (last_beat) begin
               state_nxt = ST_AWAIT_TRANSMIT_OUTCOME;
            end
         end
         ST_BUILD_DEVICE_BITS_FRAME: begin
            if (last_beat) begin
               state_nxt = ST_AWAIT_TRANSMIT_OUTCOME;
            end
         end
         ST_AWAIT_TRANSMIT_OUTCOME: begin
            if (stat_ok) begin
               state_nxt = ST_TRANSPORT_IDLE;
               kind_nxt  = KIND_NONE;
            end else if (stat_bad) begin
               state_nxt = dcf_build_state(kind_r);
            end
         end
         default: begin
            state_nxt = ST_TRANSPORT_IDLE;
            kind_nxt  = KIND_NONE;
         end
      endcase
   end

   // State and kind
   // Kind is kept through the wait so a retry knows which build state to return to
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_TRANSPORT_IDLE;
         kind_r  <= KIND_NONE;
      end else begin
         state_r <= state_nxt;
         kind_r  <= kind_nxt;
      end
   end

   // Pending flags; a new request in the accept cycle survives the clear
   // Priority when several wait: register, then device bits, then PIO
   // Two requests of one kind before accept merge into a single frame
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pend_rsf_r <= 1'b0;
         pend_sdb_r <= 1'b0;
         pend_pio_r <= 1'b0;
      end else begin
         pend_rsf_r <= req_rsf | (pend_rsf_r & !take_rsf);
         pend_sdb_r <= req_sdb | (pend_sdb_r & !take_sdb);
         pend_pio_r <= req_pio | (pend_pio_r & !take_pio);
      end
   end

   // Content is caught at request time, so later register changes stay out
   // Limitation: a newer request of one kind overwrites an unsent snapshot
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         snap_rsf_r <= '0;
         snap_sdb_r <= '0;
         snap_pio_r <= '0;
      end else begin
         if (req_rsf) snap_rsf_r <= rsf_in;
         if (req_sdb) snap_sdb_r <= sdb_in;
         if (req_pio) snap_pio_r <= pio_in;
      end
   end

   // Frame image is fixed at accept and reused unchanged on resend
   // Building once costs a wide register but spares a rebuild on every retry
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         frame_r <= '0;
         len_r   <= `DCF_LEN_RSF;
      end else if (accept) begin
         frame_r <= dcf_pack(pick);
         len_r   <= dcf_len(pick);
      end
   end

   // Word index restarts for every first send and every resend
   // A killed frame also restarts at word zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         idx_r <= `DCF_IDX_ZERO;
      end else if (in_build && !kill && !last_beat) begin
         idx_r <= idx_r + `DCF_IDX_ONE;
      end else begin
         idx_r <= `DCF_IDX_ZERO;
      end
   end

   // One word per clock with no ready; the link must take every beat
   // Data is zero between frames so stale words never leak
   // Notify mirrors valid, so the link sees it on every beat
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_r <= '0;
      end else begin
         tx_r.notify <= in_build && !kill;
         tx_r.valid  <= in_build && !kill;
         tx_r.last   <= last_beat && !kill;
         tx_r.data   <= (in_build && !kill) ? frame_r[idx_r] : '0;
      end
   end

   // Ending status: report on error, tell the application on success
   // All of these are one-cycle pulses; err is always high with a report
   // A report is issued once per failed status
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rep_r      <= '0;
         done_r     <= 1'b0;
         abandon_r  <= 1'b0;
         pio_next_r <= 1'b0;
      end else begin
         rep_r.valid <= stat_bad;
         rep_r.err   <= stat_bad;
         done_r      <= stat_ok;
         abandon_r   <= kill;
         pio_next_r  <= stat_ok && (kind_r == KIND_PIO);
      end
   end

   // Direction of the single data frame that must follow a PIO setup
   // Read from the frame image, so a PIO request queued during the wait
   // cannot change the direction of the frame in flight
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pio_dir_r <= 1'b0;
      end else if (stat_ok && (kind_r == KIND_PIO)) begin
         pio_dir_r <= frame_view.w0_flags.dir;
      end
   end

   // Outputs
   // Busy is combinational from the state register
   assign tx            = tx_r;
   assign rep           = rep_r;
   assign busy          = !in_idle;
   assign done          = done_r;
   assign abandoned     = abandon_r;
   assign pio_data_next = pio_next_r;
   assign pio_data_dir  = pio_dir_r;

endmodule
`default_nettype wire

// ### dcf_asserts.sv
// Port-level assertions for the control frame transmitter
`timescale 1ns/100ps
`default_nettype none
`include "dcf_consts.svh"
module dcf_asserts (
   input wire logic               mclk,
   input wire logic               resetn,
   input wire logic               req_rsf,
   input wire logic               link_rx_start,
   input wire logic               link_illegal,
   input wire dcf_pkg::dcf_stat_s link_stat,
   input wire dcf_pkg::dcf_tx_s   tx,
   input wire dcf_pkg::dcf_stat_s rep,
   input wire logic               busy,
   input wire logic               done,
   input wire logic               abandoned,
   input wire logic               pio_data_next
);
   import dcf_pkg::*;
   logic       await_r;
   logic [2:0] beat_r;
   logic [7:0] type_r;
   logic       clean_w;
   logic       bad_w;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // The block shows neither its state nor its frame kind, so rebuild both from the beats
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         await_r <= 1'b0;
         beat_r  <= 3'h0;
         type_r  <= 8'h00;
      end else begin
         if (tx.valid && tx.last) await_r <= 1'b1;
         else if (link_stat.valid) await_r <= 1'b0;
         beat_r <= tx.valid ? beat_r + 3'h1 : 3'h0;
         if (tx.valid && beat_r == 3'h0) type_r <= tx.data[7:0];
      end
   end
   // Status only counts once the last beat is out
   assign clean_w = await_r && link_stat.valid && !link_stat.err;
   assign bad_w   = await_r && link_stat.valid && link_stat.err;
   sequence s_idle_req; !busy && req_rsf && !link_rx_start; endsequence
   sequence s_launch; ##2 busy ##1 tx.valid; endsequence
   sequence s_resend; rep.valid && rep.err && busy ##1 tx.valid; endsequence
   chk_idle_launch: assert property (s_idle_req |-> s_launch)
      else $error("frame start late");
   chk_no_stall: assert property (tx.valid && !tx.last && !link_illegal |=> tx.valid)
      else $error("gap inside frame");
   chk_frame_len: assert property (tx.valid && tx.last |->
      beat_r == ((type_r == `DCF_TYPE_SDB) ? `DCF_LEN_SDB : `DCF_LEN_RSF) - 3'h1)
      else $error("wrong frame length");
   chk_clean_idle: assert property (clean_w |=> done && !busy && !rep.valid)
      else $error("clean status not closed");
   chk_err_resend: assert property (bad_w |=> s_resend)
      else $error("error not reported and resent");
   chk_await_quiet: assert property (await_r && !link_stat.valid |=> !tx.valid && !done && !rep.valid)
      else $error("acted before status");
   chk_done_cause: assert property (done |-> $past(clean_w))
      else $error("done without clean status");
   chk_abandon_cause: assert property (abandoned |-> $past(link_illegal) && !tx.valid && !done)
      else $error("abandon without notice");
   chk_pio_follow: assert property (pio_data_next |-> $past(clean_w))
      else $error("data frame cue misplaced");
   chk_notify_beat: assert property (tx.notify == tx.valid)
      else $error("notify not with beat");
endmodule
bind dcf_transmitter dcf_asserts u_dcf_asserts (.mclk, .resetn, .req_rsf, .link_rx_start, .link_illegal,
   .link_stat, .tx, .rep, .busy, .done, .abandoned, .pio_data_next);
`default_nettype wire

// ### dcf_link_model.sv
// Link layer stand-in: takes every beat and returns an ending status
`timescale 1ns/100ps
`default_nettype none
module dcf_link_model (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire dcf_pkg::dcf_tx_s tx,
   input  wire logic [1:0]       errs,
   input  wire logic [3:0]       delay,
   output var  dcf_pkg::dcf_stat_s link_stat
);
   import dcf_pkg::*;
   logic [4:0] wait_r;
   logic [1:0] fails_r;
   // No ready exists, so every beat is simply taken; status follows the last beat after a delay
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wait_r    <= 5'h00;
         fails_r   <= 2'h0;
         link_stat <= '0;
      end else begin
         link_stat.valid <= 1'b0;
         link_stat.err   <= ~link_stat.err; // Meaningless between pulses, so keep it moving
         if (tx.valid && tx.last) wait_r <= {1'b0, delay} + 5'h01;
         else if (wait_r == 5'h01) begin
            link_stat.valid <= 1'b1;
            link_stat.err   <= fails_r < errs;
            fails_r         <= (fails_r < errs) ? fails_r + 2'h1 : 2'h0;
            wait_r          <= 5'h00;
         end else if (wait_r != 5'h00) wait_r <= wait_r - 5'h01;
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the control frame transmitter
`timescale 1ns/100ps
`default_nettype none
`include "dcf_consts.svh"
module tb_top;
   import dcf_pkg::*;
   logic        mclk, resetn, req_rsf, req_sdb, req_pio, link_rx_start, link_illegal;
   logic        busy, done, abandoned, pio_data_next, pio_data_dir;
   logic [1:0]  lm_errs;
   logic [3:0]  lm_delay;
   dcf_regs_s   rsf_in;
   dcf_sdb_s    sdb_in;
   dcf_pio_s    pio_in;
   dcf_stat_s   link_stat, rep;
   dcf_tx_s     tx;
   logic [31:0] got[$];
   logic [31:0] exp_q[$];
   int          miscompares = 0;
   int          compares = 0;
   int          n_done, n_rep, n_aband, n_pnext;
   dcf_transmitter dut (.mclk, .resetn, .req_rsf, .rsf_in, .req_sdb, .sdb_in, .req_pio, .pio_in,
      .link_rx_start, .link_illegal, .link_stat, .tx, .rep, .busy, .done, .abandoned, .pio_data_next,
      .pio_data_dir);
   dcf_link_model u_link (.mclk, .resetn, .tx, .errs(lm_errs), .delay(lm_delay), .link_stat);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Sample on the edge, before the block's own updates land
   always @(posedge mclk) begin
      if (tx.valid === 1'b1) got.push_back(tx.data);
      n_done  += (done === 1'b1);
      n_rep   += (rep.valid === 1'b1 && rep.err === 1'b1);
      n_aband += (abandoned === 1'b1);
      n_pnext += (pio_data_next === 1'b1);
   end
   task automatic summarize();
      $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic start();
      got.delete();
      exp_q.delete();
      {n_done, n_rep, n_aband, n_pnext} = '0;
   endtask
   // Expected words built field by field; a two-word frame has an empty second word
   function automatic void push_frame(input logic [7:0] typ, input dcf_pio_s p, input logic two);
      dcf_rfis_s r;
      r = '0;
      r.w0_type = typ;
      r.w0_status = p.regs.status;
      r.w0_error = p.regs.error;
      r.w0_flags.irq = p.regs.irq;
      r.w0_flags.dir = p.dir;
      r.w1_device = p.regs.device;
      r.w1_lba_lo = p.regs.lba[23:0];
      r.w2_lba_hi = p.regs.lba[47:24];
      r.w3_count = p.regs.count;
      r.w3_estatus = p.estatus;
      r.w4_xfer = p.xfer;
      for (int i = 0; i < (two ? 2 : 5); i++) exp_q.push_back((two && i == 1) ? 32'h0000_0000 : r[32*i +: 32]);
   endfunction
   function automatic dcf_pio_s sdb_as_pio();
      dcf_pio_s p;
      p = '0;
      p.regs.status = sdb_in.status;
      p.regs.error = sdb_in.error;
      p.regs.irq = sdb_in.irq;
      return p;
   endfunction
   task automatic pulse_req(input int kind);
      @(posedge mclk);
      #1;
      case (kind)
         0: req_rsf = 1'b1;
         1: req_sdb = 1'b1;
         default: req_pio = 1'b1;
      endcase
      @(posedge mclk);
      #1;
      {req_rsf, req_sdb, req_pio} = 3'h0;
   endtask
   // Bounded wait for frames to finish or be dropped
   task automatic wait_ends(input int want);
      int k;
      k = 0;
      while (n_done + n_aband < want && k < 300) begin
         @(posedge mclk);
         k++;
      end
      if (k == 300) begin
         miscompares++;
         $display("[FAIL] %0t wait for frame end ran out", $time);
         summarize();
      end else begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic expect_beats();
      check(got.size(), exp_q.size());
      foreach (exp_q[i]) check(got[i], exp_q[i]);
   endtask
   task automatic t_rsf_clean();
      start();
      rsf_in = {8'h50, 8'h01, 8'he0, 48'h1234_5678_9abc, 16'h00a5, 1'b1};
      push_frame(`DCF_TYPE_RSF, '{regs: rsf_in, default: '0}, 1'b0);
      pulse_req(0);
      rsf_in = ~rsf_in;
      wait_ends(1);
      expect_beats();
      check(n_done, 1);
      $display("Test rsf_clean finished");
   endtask
   task automatic t_sdb();
      start();
      lm_delay = 4'h6;
      sdb_in = {8'h41, 8'h04, 1'b1};
      push_frame(`DCF_TYPE_SDB, sdb_as_pio(), 1'b1);
      pulse_req(1);
      wait_ends(1);
      expect_beats();
      check(n_done, 1);
      $display("Test sdb_slow_link finished");
   endtask
   task automatic t_pio();
      start();
      pio_in = {8'h58, 8'h00, 8'ha0, 48'h0000_0010_2030, 16'h0001, 1'b1, 8'h50, 16'h0200, 1'b1};
      push_frame(`DCF_TYPE_PIO, pio_in, 1'b0);
      pulse_req(2);
      wait_ends(1);
      expect_beats();
      check(n_pnext, 1);
      check(pio_data_dir, 1);
      $display("Test pio_setup finished");
   endtask
   task automatic t_retry();
      start();
      lm_errs = 2'h1;
      lm_delay = 4'h2;
      push_frame(`DCF_TYPE_RSF, '{regs: rsf_in, default: '0}, 1'b0);
      push_frame(`DCF_TYPE_RSF, '{regs: rsf_in, default: '0}, 1'b0);
      pulse_req(0);
      wait_ends(1);
      expect_beats();
      check(n_rep, 1);
      lm_errs = 2'h0;
      $display("Test error_retry finished");
   endtask
   task automatic t_abandon();
      start();
      pulse_req(2);
      for (int k = 0; k < 20 && got.size() < 2; k++) begin
         @(posedge mclk);
         #1;
      end
      link_illegal = 1'b1;
      @(posedge mclk);
      #1;
      link_illegal = 1'b0;
      wait_ends(1);
      check(got.size(), 3);
      check(n_aband, 1);
      check(n_done + n_pnext, 0);
      $display("Test illegal_abandon finished");
   endtask
   // Arriving frame blocks the start; later requests queue behind the one in flight
   task automatic t_queue();
      start();
      lm_delay = 4'h4;
      link_rx_start = 1'b1;
      pulse_req(1);
      repeat (4) @(posedge mclk);
      #1;
      check(got.size(), 0);
      check(busy, 0);
      link_rx_start = 1'b0;
      pio_in.dir = 1'b0;
      push_frame(`DCF_TYPE_SDB, sdb_as_pio(), 1'b1);
      push_frame(`DCF_TYPE_RSF, '{regs: rsf_in, default: '0}, 1'b0);
      push_frame(`DCF_TYPE_PIO, pio_in, 1'b0);
      pulse_req(2);
      pulse_req(0);
      wait_ends(3);
      expect_beats();
      check(n_done, 3);
      check(pio_data_dir, 0);
      $display("Test pending_order finished");
   endtask
   initial begin
      resetn = 1'b0;
      {req_rsf, req_sdb, req_pio, link_rx_start, link_illegal} = 5'h00;
      rsf_in = '0;
      sdb_in = '0;
      pio_in = '0;
      lm_errs = 2'h0;
      lm_delay = 4'h0;
      repeat (6) @(posedge mclk);
      #1;
      resetn = 1'b1;
      t_rsf_clean();
      t_sdb();
      t_pio();
      t_retry();
      t_abandon();
      t_queue();
      summarize();
   end
endmodule
`default_nettype wire
